/* sdram_style_flash_front_end.sv */
// sdram_style_flash_front_end.sv
// command decode, bank rows, burst engine, read latency pipe, mode
// register with shadow copy, initialisation timer and status
// assumes command, address and dq pins are driven on ref_clk by the
// controller; the reset/power-down pin is asynchronous
`timescale 1ns/10ps
`default_nettype none
module sdram_style_flash_front_end
   import flash_fe_pkg::*;
#(
   parameter int          DATA_W      = 16,
   parameter int          ROW_W       = (DATA_W == 32) ? 11 : 12,
   parameter int unsigned INIT_CYCLES = INIT_CYC,
   parameter logic [MODE_W-1:0] NV_DEFAULT = NV_RESET
)(
   input  wire logic              ref_clk,
   input  wire logic              arst_n,
   input  wire logic              reset_powerdown_pin,
   input  wire cmd_pins_s         cmd_pins,
   input  wire logic              bank_select_low,
   input  wire logic              bank_select_high,
   input  wire logic [MODE_W-1:0] addr,
   input  wire logic [DATA_W-1:0] dq_in,
   output logic      [DATA_W-1:0] dq_out,
   output logic                   dq_oe,
   output logic      [1:0]        arr_bank,
   output logic      [ROW_W-1:0]  arr_row,
   output logic      [COL_W-1:0]  arr_col,
   output logic                   arr_rd,
   input  wire logic [DATA_W-1:0] arr_rdata,
   output logic                   wr_stb,
   output logic      [DATA_W-1:0] wr_data,
   output logic      [7:0]        status_reg,
   output logic      [MODE_W-1:0] mode_reg,
   output logic                   deep_powerdown
);

   localparam int CNT_W = $clog2(INIT_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INIT_CYCLES - 1);

   // ----------------------------------------------------------------
   // reset/power-down pin synchroniser
   // ----------------------------------------------------------------
   logic rp_s1_ff;
   logic rp_s2_ff;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rp_s1_ff <= 1'b0;
         rp_s2_ff <= 1'b0;
      end else begin
         rp_s1_ff <= reset_powerdown_pin;
         rp_s2_ff <= rp_s1_ff;
      end
   end

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   state_e            state_ff;
   state_e            nxt_state;
   logic [CNT_W-1:0]  cnt_ff;
   logic [MODE_W-1:0] mode_ff;
   logic [MODE_W-1:0] nv_ff;
   logic [7:0]        status_ff;
   logic              deep_pd_ff;
   logic [BANKS-1:0]  open_ff;
   logic [ROW_W-1:0]  row_ff [BANKS];

   cmd_e       cmd;
   logic [1:0] bank_sel;
   logic       live;
   logic       act_take;
   logic       rd_take;
   logic       wr_take;
   logic       bst_take;
   logic       aterm_take;
   logic       lmr_take;
   logic       lcr_take;
   logic       init_take;
   logic       nvp_take;
   logic       enter_init;
   logic       init_end;

   // pins are synchronous to ref_clk; decisions land on the next edge
   assign cmd        = decode_cmd(cmd_pins);
   assign bank_sel   = {bank_select_high, bank_select_low};
   assign live       = rp_s2_ff && (state_ff == ST_STANDBY);
   assign act_take   = live && (cmd == C_ACT);
   // a read or write to a closed bank is dropped
   assign rd_take    = live && (cmd == C_RD) && open_ff[bank_sel];
   assign wr_take    = live && (cmd == C_WR) && open_ff[bank_sel];
   assign bst_take   = live && (cmd == C_BST);
   assign aterm_take = live && (cmd == C_ATERM);
   // mode load is taken whenever standby; idle banks are on the host
   assign lmr_take   = live && (cmd == C_LMR);
   // the software sequence is a load-command carrying a code
   assign lcr_take   = live && (cmd == C_LCR);
   assign init_take  = lcr_take && (addr[7:0] == CODE_INIT);
   assign nvp_take   = lcr_take && (addr[7:0] == CODE_NV_PGM);
   assign init_end   = (state_ff == ST_INIT) && (cnt_ff == CNT_LAST);
   assign enter_init = (nxt_state == ST_INIT) && (state_ff != ST_INIT);

   // ----------------------------------------------------------------
   // mode register fields
   // ----------------------------------------------------------------
   logic [2:0] bl_code;
   logic       ilv;
   logic [2:0] cl_raw;
   logic [1:0] lat;
   logic [2:0] wr_code;

   assign bl_code = norm_len(mode_ff[BL_LSB +: 3]);
   assign ilv     = mode_ff[BT_BIT];
   assign cl_raw  = mode_ff[CL_LSB +: 3];
   // reserved latency codes run as latency one
   assign lat     = (cl_raw == 3'h2 || cl_raw == 3'h3) ? cl_raw[1:0]
                                                       : 2'h1;
   assign wr_code = mode_ff[WBM_BIT]     ? BL_1 :
                    (bl_code == BL_FULL) ? BL_8 : bl_code;

   // ----------------------------------------------------------------
   // power and initialisation sequencer
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_PWRDN: begin
            if (rp_s2_ff) nxt_state = ST_INIT;
         end
         ST_INIT: begin
            if (init_end) nxt_state = ST_STANDBY;
         end
         ST_STANDBY: begin
            if (init_take) nxt_state = ST_INIT;
         end
         default: nxt_state = ST_PWRDN;
      endcase
      if (!rp_s2_ff) nxt_state = ST_PWRDN;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff   <= ST_PWRDN;
         cnt_ff     <= '0;
         deep_pd_ff <= 1'b1;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= (nxt_state == ST_INIT && !enter_init)
                       ? cnt_ff + 1'b1 : '0;
         deep_pd_ff <= (nxt_state == ST_PWRDN);
      end
   end

   // the shadow copy survives the pin; only power-on reset reloads it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff <= NV_RESET;
         nv_ff   <= NV_DEFAULT;
      end else begin
         if (enter_init)
            mode_ff <= nv_ff;
         else if (lmr_take)
            mode_ff <= addr;
         if (nvp_take)
            nv_ff <= mode_ff;
      end
   end

   // done is set on timer expiry; init entry and pin low clear it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         status_ff <= '0;
      end else if (!rp_s2_ff) begin
         status_ff <= '0;
      end else if (init_end) begin
         status_ff[STAT_DONE] <= 1'b1;
      end else if (enter_init) begin
         status_ff[STAT_DONE] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // bank and row tracking
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         open_ff <= '0;
         row_ff  <= '{default: '0};
      end else if (!live) begin
         open_ff <= '0;
      end else begin
         if (act_take) begin
            open_ff[bank_sel] <= 1'b1;
            row_ff[bank_sel]  <= addr[ROW_W-1:0];
         end else if (aterm_take) begin
            open_ff[bank_sel] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // burst engine
   // ----------------------------------------------------------------
   logic             bst_on_ff;
   logic             bst_wr_ff;
   logic [COL_W-1:0] beat_ff;
   logic [COL_W-1:0] start_ff;
   logic [2:0]       code_ff;
   logic             ilv_ff;
   logic [COL_W-1:0] col_ff;
   logic [1:0]       bank_ff;
   logic [ROW_W-1:0] arow_ff;
   logic             arr_rd_ff;
   logic             wr_stb_ff;
   logic [DATA_W-1:0] wr_data_ff;

   logic             new_burst;
   logic             bst_last;
   logic             bst_step;
   logic [COL_W-1:0] g_start;
   logic [COL_W-1:0] g_beat;
   logic [2:0]       g_code;
   logic             g_ilv;
   logic [COL_W-1:0] g_col;

   assign new_burst = rd_take || wr_take;
   // full page never ends by count; only burst terminate, a new read or write, or leaving standby stop it
   assign bst_last  = (beat_ff == len_mask(code_ff))
                      && (code_ff != BL_FULL);
   assign bst_step  = bst_on_ff && live && !new_burst && !bst_take
                      && !bst_last;
   assign g_start   = new_burst ? addr[COL_W-1:0] : start_ff;
   assign g_beat    = new_burst ? '0 : beat_ff + 8'h01;
   assign g_code    = rd_take ? bl_code : wr_take ? wr_code : code_ff;
   assign g_ilv     = new_burst ? ilv : ilv_ff;

   burst_col_gen u_col_gen (
      .start_col  (g_start),
      .len_code   (g_code),
      .interleave (g_ilv),
      .beat       (g_beat),
      .col        (g_col)
   );

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bst_on_ff <= 1'b0;
         bst_wr_ff <= 1'b0;
         beat_ff   <= '0;
         start_ff  <= '0;
         code_ff   <= BL_1;
         ilv_ff    <= 1'b0;
         col_ff    <= '0;
         bank_ff   <= '0;
         arow_ff   <= '0;
      end else begin
         bst_on_ff <= new_burst || bst_step;
         if (new_burst) begin
            bst_wr_ff <= wr_take;
            start_ff  <= g_start;
            code_ff   <= g_code;
            ilv_ff    <= g_ilv;
            bank_ff   <= bank_sel;
            arow_ff   <= row_ff[bank_sel];
         end
         if (new_burst || bst_step) begin
            beat_ff <= g_beat;
            col_ff  <= g_col;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         arr_rd_ff  <= 1'b0;
         wr_stb_ff  <= 1'b0;
         wr_data_ff <= '0;
      end else begin
         arr_rd_ff <= rd_take || (bst_step && !bst_wr_ff);
         wr_stb_ff <= wr_take || (bst_step && bst_wr_ff);
         if (wr_take || (bst_step && bst_wr_ff))
            wr_data_ff <= dq_in;
      end
   end

   // ----------------------------------------------------------------
   // read latency pipe
   // ----------------------------------------------------------------
   // the array answers in the same cycle the column is presented
   logic [DATA_W-1:0] s0_ff;
   logic [DATA_W-1:0] s1_ff;
   logic              s0v_ff;
   logic              s1v_ff;
   logic [DATA_W-1:0] dq_out_ff;
   logic              dq_oe_ff;
   logic [DATA_W-1:0] tap_data;
   logic              tap_vld;

   assign tap_data = (lat == 2'h1) ? arr_rdata :
                     (lat == 2'h2) ? s0_ff : s1_ff;
   assign tap_vld  = (lat == 2'h1) ? arr_rd_ff :
                     (lat == 2'h2) ? s0v_ff : s1v_ff;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s0_ff     <= '0;
         s1_ff     <= '0;
         s0v_ff    <= 1'b0;
         s1v_ff    <= 1'b0;
         dq_out_ff <= '0;
         dq_oe_ff  <= 1'b0;
      end else begin
         s0_ff     <= arr_rdata;
         s1_ff     <= s0_ff;
         s0v_ff    <= arr_rd_ff;
         s1v_ff    <= s0v_ff;
         dq_out_ff <= tap_data;
         dq_oe_ff  <= tap_vld && rp_s2_ff;
      end
   end

   assign dq_out         = dq_out_ff;
   assign dq_oe          = dq_oe_ff;
   assign arr_bank       = bank_ff;
   assign arr_row        = arow_ff;
   assign arr_col        = col_ff;
   assign arr_rd         = arr_rd_ff;
   assign wr_stb         = wr_stb_ff;
   assign wr_data        = wr_data_ff;
   assign status_reg     = status_ff;
   assign mode_reg       = mode_ff;
   assign deep_powerdown = deep_pd_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_init_done :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      init_end && rp_s2_ff
      |=> status_ff[STAT_DONE] && state_ff == ST_STANDBY)
      else $error("init did not end at the timer limit");

   a_init_cmd :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      init_take && rp_s2_ff
      |=> state_ff == ST_INIT && !status_ff[STAT_DONE] && cnt_ff == '0)
      else $error("init command did not restart init");

   a_done_cause :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      $rose(status_ff[STAT_DONE]) |-> $past(init_end))
      else $error("done bit set without init end");

   a_init_load :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      state_ff == ST_INIT && $past(state_ff) != ST_INIT
      |-> mode_ff == nv_ff)
      else $error("mode not loaded from shadow copy");

   a_mode_hold :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      !$stable(mode_ff) |-> $past(lmr_take) || $past(enter_init))
      else $error("mode register changed without a load");

   a_nv_copy :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      nvp_take |=> nv_ff == $past(mode_ff))
      else $error("shadow copy not taken from mode");

   a_block_wrap :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      arr_rd_ff |-> ((col_ff ^ start_ff) & ~len_mask(code_ff)) == '0)
      else $error("burst column left its block");

   a_page_wrap :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      bst_step && code_ff == BL_FULL && col_ff == 8'hFF
      |=> col_ff == 8'h00)
      else $error("full page did not wrap to column zero");

   a_pin_low :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      !rp_s2_ff |=> status_ff == '0 && !dq_oe_ff && deep_pd_ff)
      else $error("pin low did not power down");

   a_read_lat3 :
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_take && lat == 2'h3 ##1 rp_s2_ff[*4] |-> dq_oe_ff)
      else $error("latency three data not on time");

endmodule : sdram_style_flash_front_end
`default_nettype wire

/* flash_fe_pkg.sv */
// flash_fe_pkg.sv
// constants, types and helpers shared by the flash front end files
// assumes one 50 MHz clock shared with the memory controller
package flash_fe_pkg;

   // ----------------------------------------------------------------
   // geometry and mode register layout
   // ----------------------------------------------------------------
   localparam int COL_W     = 8;
   localparam int MODE_W    = 12;
   localparam int BANKS     = 4;
   localparam int BL_LSB    = 0;
   localparam int BT_BIT    = 3;
   localparam int CL_LSB    = 4;
   localparam int WBM_BIT   = 9;
   localparam int STAT_DONE = 7;

   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;

   // shadow copy content on first power-up: latency 2, sequential, 1
   localparam logic [MODE_W-1:0] NV_RESET = 12'h020;

   // command codes carried on the address pins by load-command
   localparam logic [7:0] CODE_INIT   = 8'h01;
   localparam logic [7:0] CODE_NV_PGM = 8'h02;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int INIT_TIME_US = 100;
   localparam int CLK_MHZ      = 50;
   localparam int INIT_CYC     = INIT_TIME_US * CLK_MHZ;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } cmd_pins_s;

   typedef enum logic [2:0] {
      C_NOP, C_ACT, C_RD, C_WR, C_BST, C_ATERM, C_LCR, C_LMR
   } cmd_e;

   typedef enum logic [1:0] {ST_PWRDN, ST_INIT, ST_STANDBY} state_e;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic cmd_e decode_cmd(input cmd_pins_s p);
      cmd_e c;
      case ({p.ras_n, p.cas_n, p.we_n})
         3'h3:    c = C_ACT;
         3'h5:    c = C_RD;
         3'h4:    c = C_WR;
         3'h6:    c = C_BST;
         3'h2:    c = C_ATERM;
         3'h1:    c = C_LCR;
         3'h0:    c = C_LMR;
         default: c = C_NOP;
      endcase
      if (p.cs_n) c = C_NOP;
      return c;
   endfunction : decode_cmd

   // reserved length codes fall back to single beats
   function automatic logic [2:0] norm_len(input logic [2:0] c);
      if (c == BL_2 || c == BL_4 || c == BL_8 || c == BL_FULL)
         return c;
      return BL_1;
   endfunction : norm_len

   // block mask; equals beat count minus one for bounded bursts
   function automatic logic [COL_W-1:0] len_mask(input logic [2:0] c);
      case (c)
         BL_2:    return 8'h01;
         BL_4:    return 8'h03;
         BL_8:    return 8'h07;
         BL_FULL: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction : len_mask

endpackage : flash_fe_pkg

/* burst_col_gen.sv */
// burst_col_gen.sv
// column of one burst beat from start column, length, order and index
// assumes the length code is already normalised
`timescale 1ns/10ps
`default_nettype none
module burst_col_gen
   import flash_fe_pkg::*;
(
   input  wire logic [COL_W-1:0] start_col,
   input  wire logic [2:0]       len_code,
   input  wire logic             interleave,
   input  wire logic [COL_W-1:0] beat,
   output logic      [COL_W-1:0] col
);

   logic [COL_W-1:0] mask;
   logic [COL_W-1:0] seq_col;
   logic [COL_W-1:0] ilv_col;
   logic             use_ilv;

   assign mask    = len_mask(len_code);
   assign seq_col = start_col + beat;
   assign ilv_col = start_col ^ beat;
   // full page never interleaves; it walks on and wraps the row
   assign use_ilv = interleave && (len_code != BL_FULL);
   // upper bits pick the block, lower bits wrap inside it
   assign col = (start_col & ~mask)
              | ((use_ilv ? ilv_col : seq_col) & mask);

endmodule : burst_col_gen
`default_nettype wire

/* flash_array_model.sv */
// flash_array_model.sv
// array side stand-in: read data built from the array address
// assumes the front end samples read data one edge after the address
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
   import flash_fe_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int ROW_W  = 12
)(
   input  wire logic [1:0]        arr_bank,
   input  wire logic [ROW_W-1:0]  arr_row,
   input  wire logic [COL_W-1:0]  arr_col,
   output logic      [DATA_W-1:0] arr_rdata
);
   // bank, low row bits and column in the data so a wrong address shows
   assign arr_rdata = DATA_W'({arr_bank, arr_row[5:0], arr_col});
endmodule : flash_array_model
`default_nettype wire

/* sdram_style_flash_front_end_tb.sv */
// sdram_style_flash_front_end_tb.sv
// self-checking bench: init, bursts, writes, shadow copy, power-down
// assumes INIT_CYCLES shortened to 20 and a 16-bit build
`timescale 1ns/10ps
`default_nettype none
module sdram_style_flash_front_end_tb
   import flash_fe_pkg::*;
;
   logic              ref_clk, arst_n, reset_powerdown_pin;
   cmd_pins_s         cmd_pins;
   logic              bank_select_low, bank_select_high;
   logic [MODE_W-1:0] addr, mode_reg;
   logic [15:0]       dq_in, dq_out, wr_data, arr_rdata;
   logic              dq_oe, arr_rd, wr_stb, deep_powerdown;
   logic [1:0]        arr_bank;
   logic [11:0]       arr_row;
   logic [COL_W-1:0]  arr_col;
   logic [7:0]        status_reg;
   int                n_errors, num_checks;
   localparam logic [11:0] ROW      = 12'h9A5;
   localparam cmd_pins_s   NOP_PINS = 4'hF;
   localparam cmd_pins_s   BST_PINS = 4'h6;

   sdram_style_flash_front_end #(.DATA_W(16), .INIT_CYCLES(20)) u_dut (
      .ref_clk(ref_clk), .arst_n(arst_n),
      .reset_powerdown_pin(reset_powerdown_pin), .cmd_pins(cmd_pins),
      .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
      .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col),
      .arr_rd(arr_rd), .arr_rdata(arr_rdata), .wr_stb(wr_stb),
      .wr_data(wr_data), .status_reg(status_reg), .mode_reg(mode_reg),
      .deep_powerdown(deep_powerdown));

   flash_array_model #(.DATA_W(16), .ROW_W(12)) u_array (
      .arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col),
      .arr_rdata(arr_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one command cycle, pins back to idle at the edge that takes it
   task automatic cmd(logic [2:0] c, logic [1:0] b, logic [11:0] a);
      @(posedge ref_clk);
      cmd_pins <= cmd_pins_s'({1'b0, c});
      {bank_select_high, bank_select_low} <= b;
      addr <= a;
      @(posedge ref_clk);
      cmd_pins <= NOP_PINS;
   endtask : cmd

   task automatic wait_init();
      int i;
      for (i = 0; i < 200 && status_reg[7] !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (i == 200) begin
         n_errors++;
         $display("ERROR init done flag never rose");
         tally_and_finish();
      end
   endtask : wait_init

   // load mode, open bank 2, read n beats; full page is cut by terminate
   task automatic rd(logic [11:0] mode, logic [7:0] s, int n);
      logic [7:0] m, o;
      int k, i, f, r;
      m = (mode[2:0] == 3'h7) ? 8'hFF : 8'((9'h1 << mode[2:0]) - 9'h1);
      k = 0;
      r = 0;
      f = -1;
      cmd(3'h0, 2'h0, mode);
      #1 chk("mode", 16'(mode), 16'(mode_reg));
      cmd(3'h3, 2'h2, ROW);
      cmd(3'h5, 2'h2, {4'h0, s});
      for (i = 0; i < 40; i++) begin
         #1;
         if (arr_rd === 1'b1) r++;
         if (dq_oe === 1'b1) begin
            o = mode[3] ? s ^ 8'(k) : s + 8'(k);
            if (k == 0) f = i;
            if (k < n) chk("beat", {2'h2, ROW[5:0], (s & ~m) | (o & m)}, dq_out);
            k++;
         end
         @(posedge ref_clk);
         cmd_pins <= (mode[2:0] == 3'h7 && k >= n) ? BST_PINS : NOP_PINS;
      end
      chk("latency", 16'(mode[6:4]), 16'(f));
      chk("reads", 16'(k), 16'(r));
      chk("row", 16'(ROW), 16'(arr_row));
      if (mode[2:0] == 3'h7) chk("stopped", 16'h1, 16'(k <= n + 4));
      else chk("beats", 16'(n), 16'(k));
      cmd(3'h2, 2'h2, 12'h000);
   endtask : rd

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_init();
      #1 chk("powerdown", 16'h1, 16'(deep_powerdown));
      @(posedge ref_clk);
      reset_powerdown_pin <= 1'b1;
      wait_init();
      chk("status", 16'h0080, 16'(status_reg));
      chk("awake", 16'h0, 16'(deep_powerdown));
      chk("mode load", 16'h0020, 16'(mode_reg));
   endtask : t_init

   task automatic t_bursts();
      rd(12'h022, 8'h05, 4);
      rd(12'h01B, 8'h05, 8);
      rd(12'h018, 8'h47, 1);
      rd(12'h031, 8'h81, 2);
      rd(12'h037, 8'hFE, 4);
   endtask : t_bursts

   // one write burst to bank 1; n is the beat count the mode calls for
   task automatic wr(logic [11:0] mode, logic [7:0] s, int n);
      int i, k;
      logic [7:0] m, o;
      m = 8'(n - 1);
      k = 0;
      cmd(3'h0, 2'h0, mode);
      cmd(3'h3, 2'h1, ROW);
      cmd(3'h4, 2'h1, {4'h0, s});
      for (i = 0; i < 12; i++) begin
         #1;
         if (wr_stb === 1'b1) begin
            o = (s & ~m) | ((s + 8'(k)) & m);
            chk("write col", 16'(o), 16'(arr_col));
            chk("write data", 16'hC3A5, wr_data);
            k++;
         end
         @(posedge ref_clk);
      end
      chk("write beats", 16'(n), 16'(k));
      cmd(3'h2, 2'h1, 12'h000);
   endtask : wr

   task automatic t_write();
      wr(12'h222, 8'h03, 1);
      wr(12'h027, 8'h03, 8);
   endtask : t_write

   task automatic t_shadow();
      cmd(3'h0, 2'h0, 12'h013);
      cmd(3'h1, 2'h0, 12'h002);
      cmd(3'h0, 2'h0, 12'h020);
      cmd(3'h1, 2'h0, 12'h001);
      #1 chk("init busy", 16'h0000, 16'(status_reg));
      wait_init();
      chk("shadow", 16'h0013, 16'(mode_reg));
   endtask : t_shadow

   // pin low in the middle of a full page read, then a pin-driven init
   task automatic t_pwrdn();
      cmd(3'h0, 2'h0, 12'h017);
      cmd(3'h3, 2'h2, ROW);
      cmd(3'h5, 2'h2, 12'h000);
      @(posedge ref_clk);
      reset_powerdown_pin <= 1'b0;
      #1 chk("driving", 16'h1, 16'(dq_oe));
      repeat (4) @(posedge ref_clk);
      #1 chk("cleared", 16'h0000, 16'(status_reg));
      chk("asleep", 16'h1, 16'(deep_powerdown));
      chk("released", 16'h0, 16'(dq_oe));
      chk("no reads", 16'h0, 16'(arr_rd));
      @(posedge ref_clk);
      reset_powerdown_pin <= 1'b1;
      wait_init();
      chk("pin init", 16'h0080, 16'(status_reg));
      chk("pin reload", 16'h0013, 16'(mode_reg));
   endtask : t_pwrdn

   initial begin
      n_errors = 0;
      num_checks = 0;
      arst_n = 1'b0;
      reset_powerdown_pin = 1'b0;
      cmd_pins = NOP_PINS;
      {bank_select_high, bank_select_low} = 2'h0;
      addr = 12'h000;
      dq_in = 16'hC3A5;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_init();
      t_bursts();
      t_write();
      t_shadow();
      t_pwrdn();
      tally_and_finish();
   end
endmodule : sdram_style_flash_front_end_tb
`default_nettype wire
